// >>> rtc_pkg.sv
/*
 * shared constants and types for the clock register block.
 * assumes a 100 MHz system clock and a 32,768 Hz oscillator tick enable input.
 */
package rtc_pkg;
	// ------------------------------------------------------------
	// register addresses
	// ------------------------------------------------------------
	localparam logic [16:0] clock_control_and_trim_addr = 17'h1fff8;
	localparam logic [16:0] seconds_and_osc_halt_addr   = 17'h1fff9;
	localparam logic [16:0] minutes_bcd_addr            = 17'h1fffa;
	localparam logic [16:0] hours_bcd_addr              = 17'h1fffb;
	localparam logic [16:0] weekday_bcd_addr            = 17'h1fffc;
	localparam logic [16:0] day_of_month_bcd_addr       = 17'h1fffd;
	localparam logic [16:0] month_bcd_addr              = 17'h1fffe;
	localparam logic [16:0] year_bcd_addr               = 17'h1ffff;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int time_set_hold_bit = 7;
	localparam int snapshot_hold_bit = 6;
	localparam int cal_sign_bit      = 5;
	localparam int osc_halt_bit      = 7;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] control_reset = 8'h00;
	localparam logic       osc_halt_reset = 1'b1;
	localparam logic [7:0] month_reset   = 8'h01;
	localparam logic [7:0] date_reset    = 8'h01;
	localparam logic [7:0] day_reset     = 8'h01;
	// ------------------------------------------------------------
	// divider and calibration counts
	// ------------------------------------------------------------
	localparam int osc_hz          = 32768;
	localparam int cal_stage_div   = 128;
	localparam int stage_per_sec   = osc_hz / cal_stage_div;
	localparam int cal_add_cycles  = 256;
	localparam int cal_sub_cycles  = 128;
	localparam int cal_cycle_min   = 64;
	localparam int cal_last_min    = 62;
	// ------------------------------------------------------------
	// carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hour;
		logic [7:0] day;
		logic [7:0] date;
		logic [7:0] month;
		logic [7:0] year;
	} time_regs_t;
	typedef struct packed {
		logic        set_hold;
		logic        snap_hold;
		logic        sign;
		logic [4:0]  mag;
	} control_t;
endpackage : rtc_pkg

// >>> bcd_digit_counter.sv
/*
 * one bcd field counter with wrap.
 * assumes loads and steps come from the same clock domain.
 */
module bcd_digit_counter (
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       load_in,
	input  wire logic [7:0] load_val_in,
	input  wire logic       step_in,
	input  wire logic [7:0] min_in,
	input  wire logic [7:0] max_in,
	input  wire logic [7:0] rst_val_in,
	output logic [7:0]      val_out,
	output logic            wrap_out
);
	logic [7:0] val_q;
	logic [7:0] val_d;
	// ------------------------------------------------------------
	// next value
	// ------------------------------------------------------------
	always_comb begin
		val_d    = val_q;
		wrap_out = 1'b0;
		if (load_in) begin
			val_d = load_val_in;
		end else if (step_in) begin
			if (val_q >= max_in) begin
				val_d    = min_in;
				wrap_out = 1'b1;
			end else if (val_q[3:0] == 4'h9) begin
				val_d = {val_q[7:4] + 4'h1, 4'h0};
			end else begin
				val_d = {val_q[7:4], val_q[3:0] + 4'h1};
			end
		end
	end
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			val_q <= rst_val_in;
		end else begin
			val_q <= val_d;
		end
	end
	assign val_out = val_q;
endmodule : bcd_digit_counter

// >>> rtc_set_stop_calibration.sv
/*
 * timekeeping registers at the top eight bytes of a byte-wide sram map.
 * assumes sram bus strobes are already synchronous, and osc_tick_in is a
 * one-cycle pulse per 32,768 Hz oscillator edge from the same clock domain.
 */
// Functional notes
// - control bit 7 set holds visible time registers from counter refresh
// - clearing set hold copies all seven time registers into counters at once
// - first advance after set hold clear comes one full second later
// - seconds bit 7 halts the oscillator whenever written one
// - clearing oscillator halt restarts counting one second afterwards
// - oscillator halt comes out of reset set to one
// - calibration acts on the divide-by-128 stage of the 32,768 Hz chain
// - control bits 4..0 give unsigned calibration magnitude 0 to 31
// - control bit 5 one adds counts, zero removes counts
// - 64-minute cycle; one second per minute altered by 256 or 128 cycles
// - magnitude n corrects the first 2n minutes of each cycle
// - control bit 6 freezes visible registers; resumes within one second
// - freezing visible registers never disturbs the real counters
module rtc_set_stop_calibration (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        osc_tick_in,
	input  wire logic [16:0] addr_in,
	input  wire logic        rd_in,
	input  wire logic        wr_in,
	input  wire logic [7:0]  wdata_in,
	output logic [7:0]       rdata_out,
	output logic             sec_pulse_out
);
	rtc_pkg::control_t   ctrl_q, ctrl_d;
	rtc_pkg::time_regs_t vis_q, vis_d;
	rtc_pkg::time_regs_t cnt;
	logic                halt_q, halt_d;
	logic                hold_q, hold_d;
	logic [7:0]          rdata_q, rdata_d;
	logic [6:0]          pre_q, pre_d;
	logic [7:0]          stage_q, stage_d;
	logic [5:0]          cal_min_q, cal_min_d;
	logic                cal_done_q, cal_done_d;
	logic                load;
	logic                sec_tick;
	logic                tick_fast;
	logic [6:0]          pre_limit;
	logic                stage_wrap;
	logic [6:0]          wraps;
	logic [7:0]          mins [7];
	logic [7:0]          maxs [7];
	logic [7:0]          rvals [7];
	logic [7:0]          loads [7];
	logic [7:0]          vals [7];
	logic [7:0]          stage_step;

	// ------------------------------------------------------------
	// register writes and reads
	// ------------------------------------------------------------
	always_comb begin
		ctrl_d  = ctrl_q;
		halt_d  = halt_q;
		vis_d   = vis_q;
		rdata_d = rdata_q;
		load    = 1'b0;
		if (wr_in) begin
			case (addr_in)
				rtc_pkg::clock_control_and_trim_addr: begin
					ctrl_d = rtc_pkg::control_t'(wdata_in);
					load   = ctrl_q.set_hold && !wdata_in[rtc_pkg::time_set_hold_bit];
				end
				rtc_pkg::seconds_and_osc_halt_addr: begin
					halt_d    = wdata_in[rtc_pkg::osc_halt_bit];
					vis_d.sec = {1'b0, wdata_in[6:0]};
				end
				rtc_pkg::minutes_bcd_addr:      vis_d.min   = wdata_in;
				rtc_pkg::hours_bcd_addr:        vis_d.hour  = wdata_in;
				rtc_pkg::weekday_bcd_addr:      vis_d.day   = wdata_in;
				rtc_pkg::day_of_month_bcd_addr: vis_d.date  = wdata_in;
				rtc_pkg::month_bcd_addr:        vis_d.month = wdata_in;
				rtc_pkg::year_bcd_addr:         vis_d.year  = wdata_in;
				default: begin
				end
			endcase
		end else if (!ctrl_q.set_hold && !ctrl_q.snap_hold) begin
			vis_d = cnt;
		end
		if (rd_in) begin
			case (addr_in)
				rtc_pkg::clock_control_and_trim_addr: rdata_d = ctrl_q;
				rtc_pkg::seconds_and_osc_halt_addr:   rdata_d = {halt_q, vis_q.sec[6:0]};
				rtc_pkg::minutes_bcd_addr:            rdata_d = vis_q.min;
				rtc_pkg::hours_bcd_addr:              rdata_d = vis_q.hour;
				rtc_pkg::weekday_bcd_addr:            rdata_d = vis_q.day;
				rtc_pkg::day_of_month_bcd_addr:       rdata_d = vis_q.date;
				rtc_pkg::month_bcd_addr:              rdata_d = vis_q.month;
				rtc_pkg::year_bcd_addr:               rdata_d = vis_q.year;
				default:                              rdata_d = 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------
	// divider chain with calibration at the 128 stage
	// ------------------------------------------------------------
	assign tick_fast = (cal_min_q < {ctrl_q.mag, 1'b0}) && (cal_min_q < 6'(rtc_pkg::cal_last_min))
		&& !cal_done_q && (stage_q == 8'h00);
	always_comb begin
		pre_limit  = 7'(rtc_pkg::cal_stage_div - 1);
		stage_step = 8'h01;
		if (tick_fast && ctrl_q.sign) begin
			// positive: skip two 128-count stage passes, so the second ends 256 cycles early
			stage_step = 8'(rtc_pkg::cal_add_cycles / rtc_pkg::cal_stage_div + 1);
		end
	end
	always_comb begin
		pre_d      = pre_q;
		stage_d    = stage_q;
		cal_min_d  = cal_min_q;
		cal_done_d = cal_done_q;
		hold_d     = hold_q;
		stage_wrap = 1'b0;
		sec_tick   = 1'b0;
		if (load || (halt_q && !halt_d)) begin
			pre_d   = 7'h00;
			stage_d = 8'h00;
			hold_d  = 1'b0;
		end else if (osc_tick_in && !halt_q) begin
			if (pre_q >= pre_limit) begin
				pre_d      = 7'h00;
				stage_wrap = 1'b1;
			end else begin
				pre_d = pre_q + 7'h01;
			end
		end
		if (stage_wrap) begin
			if (tick_fast && !ctrl_q.sign && !hold_q) begin
				hold_d = 1'b1; // extra 128-cycle pass on negative correction
			end else if (stage_q == 8'(rtc_pkg::stage_per_sec - 1)) begin
				stage_d  = 8'h00;
				sec_tick = 1'b1;
				hold_d   = 1'b0;
				if (tick_fast || hold_q) begin
					cal_done_d = 1'b1;
				end
			end else begin
				stage_d = stage_q + stage_step;
				if (tick_fast) begin
					cal_done_d = 1'b1; // one corrected second per minute
				end
			end
		end
		if (sec_tick && wraps[0]) begin
			cal_done_d = 1'b0;
			cal_min_d  = cal_min_q + 6'h01;
		end
	end

	// ------------------------------------------------------------
	// bcd counter chain
	// ------------------------------------------------------------
	assign mins  = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
	assign maxs  = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
	assign rvals = '{8'h00, 8'h00, 8'h00, rtc_pkg::day_reset, rtc_pkg::date_reset, rtc_pkg::month_reset, 8'h00};
	assign loads = '{{1'b0, vis_q.sec[6:0]}, vis_q.min, vis_q.hour, vis_q.day, vis_q.date, vis_q.month,
		vis_q.year};
	genvar g;
	generate
		for (g = 0; g < 7; g++) begin : g_field
			logic step;
			if (g == 0) begin : g_s
				assign step = sec_tick;
			end else if (g == 4) begin : g_d
				assign step = sec_tick && (&wraps[2:0]);
			end else if (g == 3) begin : g_w
				assign step = sec_tick && (&wraps[2:0]);
			end else if (g > 4) begin : g_h
				assign step = sec_tick && (&wraps[2:0]) && (&wraps[g-1:4]);
			end else begin : g_l
				assign step = sec_tick && (&wraps[g-1:0]);
			end
			bcd_digit_counter u_cnt (
				.clk_in      (clk_in),
				.rst_n_in    (rst_n_in),
				.load_in     (load),
				.load_val_in (loads[g]),
				.step_in     (step),
				.min_in      (mins[g]),
				.max_in      (maxs[g]),
				.rst_val_in  (rvals[g]),
				.val_out     (vals[g]),
				.wrap_out    (wraps[g])
			);
		end
	endgenerate
	assign cnt = {vals[0], vals[1], vals[2], vals[3], vals[4], vals[5], vals[6]};

	// ------------------------------------------------------------
	// state registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ctrl_q     <= rtc_pkg::control_t'(rtc_pkg::control_reset);
			halt_q     <= rtc_pkg::osc_halt_reset;
			vis_q      <= '0;
			rdata_q    <= 8'h00;
			pre_q      <= 7'h00;
			stage_q    <= 8'h00;
			cal_min_q  <= 6'h00;
			cal_done_q <= 1'b0;
			hold_q     <= 1'b0;
		end else begin
			ctrl_q     <= ctrl_d;
			halt_q     <= halt_d;
			vis_q      <= vis_d;
			rdata_q    <= rdata_d;
			pre_q      <= pre_d;
			stage_q    <= stage_d;
			cal_min_q  <= cal_min_d;
			cal_done_q <= cal_done_d;
			hold_q     <= hold_d;
		end
	end
	assign rdata_out     = rdata_q;
	assign sec_pulse_out = sec_tick;
endmodule : rtc_set_stop_calibration

// >>> rtc_props.sv
/* port checker for the clock register block.
 * assumes one clock, synchronous active-low reset. */
module rtc_props (
	input wire logic        clk_in,
	input wire logic        rst_n_in,
	input wire logic        osc_tick_in,
	input wire logic [16:0] addr_in,
	input wire logic        rd_in,
	input wire logic        wr_in,
	input wire logic [7:0]  wdata_in,
	input wire logic [7:0]  rdata_out,
	input wire logic        sec_pulse_out
);
	// ----------------------------------------
	// shadow of control and halt
	// ----------------------------------------
	logic [7:0]  ctl_q, ctl_d;
	logic        halt_q, halt_d;
	logic [16:0] cnt_q, cnt_d;
	logic        wc, ws, rs, run0;
	assign wc = wr_in && addr_in == rtc_pkg::clock_control_and_trim_addr;
	assign ws = wr_in && addr_in == rtc_pkg::seconds_and_osc_halt_addr;
	assign rs = (wc && ctl_q[7] && !wdata_in[7]) || (ws && halt_q && !wdata_in[7]);
	assign run0 = ctl_q[4:0] == 5'h00;
	always_comb begin
		ctl_d = wc ? wdata_in : ctl_q;
		halt_d = ws ? wdata_in[7] : halt_q;
		cnt_d = (sec_pulse_out || rs) ? 17'h00000 : cnt_q + 17'(osc_tick_in);
	end
	always_ff @(posedge clk_in) begin
		ctl_q <= rst_n_in ? ctl_d : 8'h00;
		halt_q <= rst_n_in ? halt_d : 1'b1;
		cnt_q <= rst_n_in ? cnt_d : 17'h00000;
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	a_halt_no_pulse: assert property (halt_q |-> !sec_pulse_out)
		else $error("second pulse while halted");
	a_ctl_readback: assert property (rd_in && !wr_in && addr_in == rtc_pkg::clock_control_and_trim_addr
		|=> rdata_out == $past(ctl_q)) else $error("control readback wrong");
	a_unmapped_zero: assert property (rd_in && addr_in < 17'h1fff8 |=> rdata_out == 8'h00)
		else $error("unmapped read not zero");
	a_halt_readback: assert property (rd_in && !wr_in && addr_in == rtc_pkg::seconds_and_osc_halt_addr
		|=> rdata_out[7] == $past(halt_q)) else $error("halt bit readback wrong");
	a_rdata_stands: assert property (!rd_in |=> $stable(rdata_out))
		else $error("read data moved without read");
	a_pulse_single: assert property (sec_pulse_out |=> !sec_pulse_out [*8])
		else $error("second pulse too wide");
	a_second_len: assert property (sec_pulse_out && run0 |-> cnt_q inside {[17'd32767:17'd32768]})
		else $error("second length wrong");
	a_no_early: assert property (run0 && cnt_q < 17'd32767 && !rs |-> !sec_pulse_out)
		else $error("early second pulse");
	c_pulse: cover property (sec_pulse_out);
	c_snap: cover property (wc && wdata_in[6]);
	c_halt: cover property (ws && wdata_in[7]);
	c_cal: cover property (wc && wdata_in[5] && wdata_in[4:0] != 5'h00);
endmodule : rtc_props

bind rtc_set_stop_calibration rtc_props rtc_props_inst (.clk_in, .rst_n_in, .osc_tick_in, .addr_in,
	.rd_in, .wr_in, .wdata_in, .rdata_out, .sec_pulse_out);

// >>> osc_model.sv
/* oscillator tick source for the clock block.
 * assumes one tick per gap system cycles. */
module osc_model #(
	parameter int gap = 1
) (
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	output logic      tick_out
);
	logic [7:0] c_q;
	assign tick_out = c_q == 8'h00;
	always_ff @(posedge clk_in) begin
		c_q <= (!rst_n_in || c_q == 8'(gap - 1)) ? 8'h00 : c_q + 8'h01;
	end
endmodule : osc_model

// >>> tb.sv
/* self-checking bench for the clock register block.
 * assumes a host doing single-byte accesses. */
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic        tick;
	logic [16:0] addr_in = 17'h00000;
	logic        rd_in = 1'b0;
	logic        wr_in = 1'b0;
	logic [7:0]  wdata_in = 8'h00;
	logic [7:0]  rdata_out;
	logic        sec_pulse_out;
	int          mismatches = 0;
	int          n_checks = 0;
	int          n;
	always #5 clk_in = ~clk_in;
	osc_model osc_model_inst (.clk_in, .rst_n_in, .tick_out(tick));
	rtc_set_stop_calibration rtc_set_stop_calibration_inst (.clk_in, .rst_n_in, .osc_tick_in(tick),
		.addr_in, .rd_in, .wr_in, .wdata_in, .rdata_out, .sec_pulse_out);
	// ----------------------------------------
	// host and compare tasks
	// ----------------------------------------
	task automatic print_verdict;
		if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t byte %h expected %h", $time, got, exp);
		end
	endtask : check8
	task automatic check_in(input int v, input int lo, input int hi);
		n_checks++;
		if (v < lo || v > hi) begin
			mismatches++;
			$display("ERROR %0t count %0d outside %0d..%0d", $time, v, lo, hi);
		end
	endtask : check_in
	task automatic wr(input logic [16:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : wr
	task automatic rd_chk(input logic [16:0] a, input logic [7:0] exp);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		@(negedge clk_in);
		check8(rdata_out, exp);
	endtask : rd_chk
	task automatic wait_pulse(output int c);
		c = 0;
		while (sec_pulse_out !== 1'b1) begin
			@(negedge clk_in);
			c++;
			if (c > 40000) begin
				mismatches++;
				print_verdict();
			end
		end
		@(posedge clk_in);
	endtask : wait_pulse
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		rd_chk(17'h1fff8, 8'h00);
		rd_chk(17'h1fff9, 8'h80);
		rd_chk(17'h1fffe, 8'h01);
		rd_chk(17'h00010, 8'h00);
	endtask : t_reset
	task automatic t_set;
		wr(17'h1fff8, 8'ha5);
		rd_chk(17'h1fff8, 8'ha5);
		wr(17'h1fff9, 8'h59);
		wr(17'h1fffa, 8'h59);
		wr(17'h1fffb, 8'h23);
		repeat (3) @(posedge clk_in);
		rd_chk(17'h1fffa, 8'h59);
		rd_chk(17'h1fff9, 8'h59);
		wr(17'h1fff8, 8'h00);
		wait_pulse(n);
		check_in(n, 32766, 32770);
		rd_chk(17'h1fff9, 8'h00);
		rd_chk(17'h1fffa, 8'h00);
		rd_chk(17'h1fffb, 8'h00);
	endtask : t_set
	task automatic t_snap;
		wr(17'h1fff8, 8'h40);
		wait_pulse(n);
		check_in(n, 32700, 32770);
		rd_chk(17'h1fff9, 8'h00);
		wr(17'h1fff8, 8'h00);
		repeat (3) @(posedge clk_in);
		rd_chk(17'h1fff9, 8'h01);
	endtask : t_snap
	task automatic t_cal;
		wr(17'h1fff8, 8'h21);
		wait_pulse(n);
		check_in(n, 32480, 32520);
		rd_chk(17'h1fff9, 8'h02);
	endtask : t_cal
	task automatic t_halt;
		wr(17'h1fff9, 8'h80);
		repeat (100) @(posedge clk_in);
		rd_chk(17'h1fff9, 8'h82);
	endtask : t_halt
	initial begin
		repeat (4) @(posedge clk_in);
		rst_n_in <= 1'b1;
		t_reset();
		t_set();
		t_snap();
		t_cal();
		t_halt();
		print_verdict();
	end
endmodule : tb
